// *** rtl/time_sync_pkg.sv ***
// Constants shared by the time synchronisation state block.
package time_sync_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;

    // Register byte offsets.
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_STATUS    = 8'h04;
    localparam logic [7:0] A_STRATUM   = 8'h08;
    localparam logic [7:0] A_PREC      = 8'h0c;
    localparam logic [7:0] A_REF_CODE  = 8'h10;
    localparam logic [7:0] A_REF_HOST  = 8'h14;
    localparam logic [7:0] A_PEER_ADDR = 8'h18;
    localparam logic [7:0] A_PEER_PORT = 8'h1c;
    localparam logic [7:0] A_LOC_ADDR  = 8'h20;
    localparam logic [7:0] A_LOC_PORT  = 8'h24;
    localparam logic [7:0] A_CLK_HI    = 8'h28;
    localparam logic [7:0] A_CLK_LO    = 8'h2c;
    localparam logic [7:0] A_INCR      = 8'h30;
    localparam logic [7:0] A_UPDATE    = 8'h34;
    localparam logic [7:0] A_HOLD      = 8'h38;
    localparam logic [7:0] A_REF_HI    = 8'h3c;
    localparam logic [7:0] A_REF_LO    = 8'h40;
    localparam logic [7:0] A_ORG_HI    = 8'h44;
    localparam logic [7:0] A_ORG_LO    = 8'h48;
    localparam logic [7:0] A_REC_HI    = 8'h4c;
    localparam logic [7:0] A_REC_LO    = 8'h50;

    // Field positions.
    localparam int CTRL_PRIMARY = 0;
    localparam int CTRL_LEAP_LO = 1;
    localparam int CTRL_MODE_LO = 3;
    localparam int UPD_SYNC     = 0;
    localparam int UPD_UNSYNC   = 1;

    // Leap warning codes.
    localparam logic [1:0] LEAP_NONE  = 2'h0;
    localparam logic [1:0] LEAP_INS   = 2'h1;
    localparam logic [1:0] LEAP_DEL   = 2'h2;
    localparam logic [1:0] LEAP_ALARM = 2'h3;

    // Association mode codes.
    typedef enum logic [2:0] {
        MODE_UNSPEC  = 3'h0,
        MODE_SYM_ACT = 3'h1,
        MODE_SYM_PAS = 3'h2,
        MODE_CLIENT  = 3'h3,
        MODE_SERVER  = 3'h4,
        MODE_BCAST   = 3'h5,
        MODE_RSV_VER = 3'h6,
        MODE_PRIVATE = 3'h7
    } assoc_mode_t;

    // Stratum values.
    localparam logic [7:0] STRATUM_UNSPEC  = 8'h00;
    localparam logic [7:0] STRATUM_PRIMARY = 8'h01;
    localparam logic [7:0] MAX_STRATUM_RST = 8'h0f;

    // Precision codes, power of two seconds.
    localparam logic [7:0] PREC_MAINS   = 8'hfa;
    localparam logic [7:0] PREC_CRYSTAL = 8'hf6;

    // Day lengths in seconds, minus one, with and without a leap second; DAY_SECS is the plain day length.
    localparam logic [16:0] DAY_LAST     = 17'h1517f;
    localparam logic [16:0] DAY_LAST_INS = 17'h15180;
    localparam logic [16:0] DAY_LAST_DEL = 17'h1517e;
    localparam logic [31:0] DAY_SECS     = 32'h00015180;

    // Fraction added per clock cycle so that one second is CLK_HZ cycles.
    localparam logic [31:0] INCR_RST = 32'((64'h1_0000_0000) / 64'(CLK_HZ));

    // Reference age after which the clock counts as unsynchronised.
    localparam int unsigned MAX_AGE_SEC = 86400;
    localparam logic [15:0] HOLD_RST    = 16'h0040;
endpackage : time_sync_pkg

// *** rtl/time_sync_state.sv ***
// Shared protocol state, local clock and hold counter behind an Avalon-MM slave.
//
// Notes on behaviour
// (RL1) Leap field two bits, four coded meanings.
// (RL2) Unsynchronised clock forces the alarm leap code.
// (RL3) Non-alarm leap bits pass out unchanged.
// (RL4) Leap warning ends after next day rollover.
// (RL5) Primary: operator leap; secondary: protocol leap.
// (RL6) Mode field codes zero to seven.
// (RL7) Stratum zero unspecified, one primary, rest secondary.
// (RL8) Stratum zero compares above every value.
// (RL9) Sent stratum never exceeds max_stratum_limit; tx_stratum resets to zero, which ranks above it.
// (RL10) Peer poll is signed power-of-two seconds.
// (RL11) Precision is signed power-of-two seconds.
// (RL12) Keep peer and local address and port.
// (RL13) Stratum zero or one: ASCII reference code.
// (RL14) Stratum two up: reference host address.
// (RL15) Reference time zero until first clock update.
// (RL16) Store origin and arrival; clear when unreachable.
// (RL17) Transmit timestamp is local time at departure.
// (RL18) Step loads hold; counts down; blocks steps.
// (RL19) Local clock advances by a programmable increment.
// (RL20) Timestamps are 64-bit, seconds then fraction.
// (RL21) All-zero timestamp means invalid.
// (RL22) Hold decrements on a one-cycle seconds tick.
// (RL23) Reserved modes stored with no other effect.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module time_sync_state
    import time_sync_pkg::*;
#(
    parameter int unsigned MAX_AGE  = MAX_AGE_SEC,
    parameter logic [15:0] HOLD_SET = HOLD_RST
) (
    input  wire logic        clk,           // 40 MHz clock
    input  wire logic        rst_n,         // Asynchronous reset, active low
    input  wire logic [7:0]  address,       // Avalon byte address
    input  wire logic        read,          // Avalon read request
    input  wire logic        write,         // Avalon write request
    input  wire logic [31:0] writedata,     // Avalon write data
    output logic      [31:0] readdata,      // Avalon read data
    output logic             waitrequest,   // Avalon wait, low to complete
    input  wire logic        rx_valid,      // Peer message received, pulse
    input  wire logic [1:0]  rx_leap,       // Received leap code
    input  wire logic [2:0]  rx_mode,       // Received mode
    input  wire logic [7:0]  rx_stratum,    // Received stratum
    input  wire logic [7:0]  rx_poll,       // Received peer poll exponent
    input  wire logic [63:0] rx_xmt_ts,     // Received send timestamp
    input  wire logic        peer_unreach,  // Peer became unreachable, pulse
    input  wire logic        tx_req,        // Message departs now, pulse
    output logic      [63:0] tx_ts,         // Departure timestamp
    output logic             tx_ts_valid,   // Departure timestamp strobe
    output logic      [1:0]  tx_leap,       // Leap code to send
    output logic      [7:0]  tx_stratum,    // Stratum to send
    output logic      [31:0] tx_refid,      // Reference identifier to send
    output logic      [2:0]  tx_mode,       // Host mode to send
    output logic      [1:0]  leap_out,      // Leap code to time conversion
    output logic             clock_synced,  // Local clock synchronised
    output logic             sec_tick       // One-cycle seconds tick
);

    typedef struct packed {
        logic        stall;
        logic [31:0] rdata;
        logic        primary;
        logic [1:0]  op_leap;
        logic [2:0]  hmode;
        logic [7:0]  stratum;
        logic [7:0]  max_strat;
        logic [7:0]  prec;
        logic [31:0] ref_code;
        logic [31:0] ref_host;
        logic [31:0] paddr;
        logic [15:0] pport;
        logic [31:0] laddr;
        logic [15:0] lport;
        logic [63:0] lclk;
        logic [31:0] lo_stage;
        logic [31:0] incr;
        logic [15:0] hold;
        logic        synced;
        logic [16:0] age;
        logic [16:0] sod;
        logic        sec_prev;
        logic        tick;
        logic [1:0]  p_leap;
        logic [2:0]  p_mode;
        logic [7:0]  p_strat;
        logic [7:0]  p_poll;
        logic [63:0] org;
        logic [63:0] rec;
        logic [63:0] reftime;
        logic [63:0] tx_ts;
        logic        tx_v;
        logic [7:0]  tx_strat;
        logic [31:0] tx_refid;
        logic [1:0]  sys_leap;
        logic        better;
    } state_t;

    state_t q;
    state_t d;
    logic   rst_meta_q;
    logic   rst_sync_n;

    // Stratum zero sorts above every other value.
    function automatic logic [8:0] strat_key(input logic [7:0] s);
        strat_key = (s == STRATUM_UNSPEC) ? 9'h100 : {1'b0, s}; // RL8
    endfunction : strat_key

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    logic        req;
    logic        acc;
    logic        do_step;
    logic [1:0]  leap_now;
    logic [16:0] day_last;
    logic [63:0] step_val;
    logic [31:0] rd;

    always_comb begin
        d        = q;
        req      = read | write;
        acc      = req & ~q.stall;
        do_step  = 1'b0;
        step_val = {writedata, q.lo_stage};
        rd       = 32'h0;

        // The clock runs on every cycle; steps below override it.
        d.lclk = q.lclk + {32'h0, q.incr}; // RL19 RL20

        // Seconds tick from the integer part's lowest bit.
        d.sec_prev = q.lclk[32];
        d.tick     = q.lclk[32] ^ q.sec_prev; // RL22

        // Bus: one wait cycle, then completion with registered data.
        d.stall = ~(req & q.stall);
        case (address)
            A_CTRL:      rd = {26'h0, q.hmode, q.op_leap, q.primary};
            A_STATUS:    rd = {17'h0, q.p_leap, 2'h0, q.p_mode, 3'h0,
                               (q.hold != 16'h0), q.better, q.synced,
                               q.sys_leap};
            A_STRATUM:   rd = {8'h0, q.p_strat, q.max_strat, q.stratum};
            A_PREC:      rd = {16'h0, q.p_poll, q.prec}; // RL10 RL11
            A_REF_CODE:  rd = q.ref_code;
            A_REF_HOST:  rd = q.ref_host;
            A_PEER_ADDR: rd = q.paddr;
            A_PEER_PORT: rd = {16'h0, q.pport};
            A_LOC_ADDR:  rd = q.laddr;
            A_LOC_PORT:  rd = {16'h0, q.lport};
            A_CLK_HI:    rd = q.lclk[63:32];
            A_CLK_LO:    rd = q.lclk[31:0];
            A_INCR:      rd = q.incr;
            A_HOLD:      rd = {16'h0, q.hold};
            A_REF_HI:    rd = q.reftime[63:32];
            A_REF_LO:    rd = q.reftime[31:0];
            A_ORG_HI:    rd = q.org[63:32];
            A_ORG_LO:    rd = q.org[31:0];
            A_REC_HI:    rd = q.rec[63:32];
            A_REC_LO:    rd = q.rec[31:0];
            default:     rd = 32'h0;
        endcase
        if (read && q.stall) begin
            d.rdata = rd;
        end

        // Hold counter counts down once a second and stops at zero.
        if (q.tick && q.hold != 16'h0) begin
            d.hold = q.hold - 16'h1; // RL18
        end

        // Reference age; too long without an update loses sync.
        if (q.tick && q.synced) begin
            if (32'(q.age) >= MAX_AGE - 1) begin
                d.synced = 1'b0; // RL2
                d.age    = 17'h0;
            end else begin
                d.age = q.age + 17'h1;
            end
        end

        // Seconds of day; a leap day is one second longer or shorter.
        leap_now = q.primary ? q.op_leap : q.p_leap; // RL5
        case (leap_now)
            LEAP_INS: day_last = DAY_LAST_INS; // RL4
            LEAP_DEL: day_last = DAY_LAST_DEL; // RL4
            default:  day_last = DAY_LAST;
        endcase
        if (q.tick) begin
            if (q.sod >= day_last) begin
                d.sod = 17'h0;
                if (leap_now == LEAP_INS || leap_now == LEAP_DEL) begin
                    if (q.primary) begin
                        d.op_leap = LEAP_NONE; // RL4
                    end else begin
                        d.p_leap = LEAP_NONE; // RL4
                    end
                end
            end else begin
                d.sod = q.sod + 17'h1;
            end
        end

        // Peer events; an arrival in the clearing cycle is kept.
        if (peer_unreach) begin
            d.org = 64'h0; // RL16 RL21
            d.rec = 64'h0; // RL16 RL21
        end
        if (rx_valid) begin
            d.p_leap  = rx_leap;
            d.p_mode  = rx_mode; // RL6 RL23
            d.p_strat = rx_stratum; // RL7
            d.p_poll  = rx_poll; // RL10
            d.org     = rx_xmt_ts; // RL16
            d.rec     = q.lclk; // RL16
        end

        // Register writes take effect on the completing edge.
        if (write && acc) begin
            case (address)
                A_CTRL: begin
                    d.primary = writedata[CTRL_PRIMARY];
                    d.op_leap = writedata[CTRL_LEAP_LO +: 2]; // RL5
                    d.hmode   = writedata[CTRL_MODE_LO +: 3]; // RL6
                end
                A_STRATUM: begin
                    d.stratum   = writedata[7:0];
                    d.max_strat = writedata[15:8];
                end
                A_PREC:      d.prec     = writedata[7:0]; // RL11
                A_REF_CODE:  d.ref_code = writedata;
                A_REF_HOST:  d.ref_host = writedata;
                A_PEER_ADDR: d.paddr    = writedata; // RL12
                A_PEER_PORT: d.pport    = writedata[15:0]; // RL12
                A_LOC_ADDR:  d.laddr    = writedata; // RL12
                A_LOC_PORT:  d.lport    = writedata[15:0]; // RL12
                A_CLK_LO:    d.lo_stage = writedata;
                A_CLK_HI:    do_step    = (q.hold == 16'h0); // RL18
                A_INCR:      d.incr     = writedata; // RL19
                A_UPDATE: begin
                    if (writedata[UPD_UNSYNC]) begin
                        d.synced = 1'b0; // RL2
                    end
                    if (writedata[UPD_SYNC]) begin
                        d.synced  = 1'b1;
                        d.age     = 17'h0;
                        d.reftime = q.lclk; // RL15
                    end
                end
                default: ;
            endcase
        end

        // A step is refused outright while the hold counter runs.
        if (do_step) begin
            d.lclk    = step_val;
            d.hold    = HOLD_SET; // RL18
            d.synced  = 1'b1;
            d.age     = 17'h0;
            d.reftime = step_val; // RL15
            d.sod     = 17'(step_val[63:32] % DAY_SECS);
        end

        // Leap code: alarm overrides everything while unsynchronised.
        if (!q.synced) begin
            d.sys_leap = LEAP_ALARM; // RL1 RL2
        end else begin
            d.sys_leap = leap_now; // RL3
        end

        // Outgoing header fields, refreshed every cycle; the departure stamp only on tx_req.
        if (strat_key(q.stratum) > strat_key(q.max_strat)) begin
            d.tx_strat = q.max_strat; // RL9
        end else begin
            d.tx_strat = q.stratum;
        end
        if (q.stratum <= STRATUM_PRIMARY) begin
            d.tx_refid = q.ref_code; // RL13
        end else begin
            d.tx_refid = q.ref_host; // RL14
        end
        d.better = strat_key(q.p_strat) < strat_key(q.stratum); // RL8

        d.tx_v = tx_req;
        if (tx_req) begin
            d.tx_ts = q.lclk; // RL17
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q           <= '0;
            q.stall     <= 1'b1;
            q.max_strat <= MAX_STRATUM_RST;
            q.prec      <= PREC_CRYSTAL;
            q.incr      <= INCR_RST;
            q.sys_leap  <= LEAP_ALARM;
            q.tx_strat  <= STRATUM_UNSPEC;
        end else begin
            q <= d;
        end
    end

    assign readdata     = q.rdata;
    assign waitrequest  = q.stall;
    assign tx_ts        = q.tx_ts;
    assign tx_ts_valid  = q.tx_v;
    assign tx_leap      = q.sys_leap;
    assign tx_stratum   = q.tx_strat;
    assign tx_refid     = q.tx_refid;
    assign tx_mode      = q.hmode;
    assign leap_out     = q.sys_leap; // RL3
    assign clock_synced = q.synced;
    assign sec_tick     = q.tick;

endmodule : time_sync_state
`default_nettype wire

// *** bench/time_sync_state_asserts.sv ***
// Port checks for the time synchronisation state block.
`timescale 1ns/1ps
`default_nettype none
module time_sync_state_asserts import time_sync_pkg::*; (
    input wire logic       clk,          // Clock
    input wire logic       rst_n,        // Reset, active low
    input wire logic       read,         // Bus read
    input wire logic       write,        // Bus write
    input wire logic       waitrequest,  // Bus wait
    input wire logic       tx_req,       // Departure strobe
    input wire logic       tx_ts_valid,  // Stamp strobe
    input wire logic [1:0] tx_leap,      // Sent leap code
    input wire logic [1:0] leap_out,     // Leap code out
    input wire logic       clock_synced, // Synchronised
    input wire logic [7:0] tx_stratum,   // Sent stratum
    input wire logic       sec_tick      // Seconds tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one cycle");
    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("wait low for more than one cycle");
    stamp_strobe_a: assert property (tx_req |=> tx_ts_valid)
        else $error("departure stamp strobe missing");
    strobe_cause_a: assert property (tx_ts_valid |-> $past(tx_req))
        else $error("stamp strobe without departure");
    unsync_alarm_a: assert property (!clock_synced [*2] |-> leap_out == LEAP_ALARM)
        else $error("unsynchronised clock without alarm code");
    leap_same_a: assert property (tx_leap == leap_out)
        else $error("sent leap code differs from leap out");
    stratum_cap_a: assert property (tx_stratum <= MAX_STRATUM_RST)
        else $error("sent stratum above limit");
    tick_single_a: assert property (sec_tick |=> !sec_tick)
        else $error("seconds tick longer than one cycle");

    cover property (tx_ts_valid);
    cover property (!waitrequest && read);
    cover property ($fell(clock_synced));
endmodule : time_sync_state_asserts
`default_nettype wire

// *** bench/peer_model.sv ***
// Behavioural remote peer that sends messages and reports loss of contact.
`timescale 1ns/1ps
`default_nettype none
module peer_model (
    input  wire logic        clk,          // Bench clock
    output logic             rx_valid,     // Message strobe
    output logic      [1:0]  rx_leap,      // Leap code sent
    output logic      [2:0]  rx_mode,      // Mode sent
    output logic      [7:0]  rx_stratum,   // Stratum sent
    output logic      [7:0]  rx_poll,      // Poll exponent sent
    output logic      [63:0] rx_xmt_ts,    // Send timestamp
    output logic             peer_unreach  // Contact lost strobe
);
    initial begin
        rx_valid = 1'b0;
        peer_unreach = 1'b0;
        {rx_leap, rx_mode, rx_stratum, rx_poll, rx_xmt_ts} = '0;
    end

    // Fields are inverted after the strobe so a stale capture cannot pass.
    task automatic send(input logic [1:0] l, input logic [2:0] m, input logic [7:0] s, p,
                        input logic [63:0] t, input int gap);
        repeat (gap) @(posedge clk);
        rx_valid <= 1'b1;
        {rx_leap, rx_mode, rx_stratum, rx_poll, rx_xmt_ts} <= {l, m, s, p, t};
        @(posedge clk);
        rx_valid <= 1'b0;
        {rx_leap, rx_mode, rx_stratum, rx_poll, rx_xmt_ts} <= ~{l, m, s, p, t};
    endtask : send

    task automatic drop();
        peer_unreach <= 1'b1;
        @(posedge clk);
        peer_unreach <= 1'b0;
    endtask : drop
endmodule : peer_model
`default_nettype wire

// *** bench/time_sync_state_tb.sv ***
// Self-checking bench for the time synchronisation state block.
`timescale 1ns/1ps
`default_nettype none
module time_sync_state_tb import time_sync_pkg::*;;
    logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, tx_req = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, q, h, tx_refid;
    logic        waitrequest, rx_valid, peer_unreach, tx_ts_valid, clock_synced, sec_tick;
    logic [1:0]  rx_leap, tx_leap, leap_out;
    logic [2:0]  rx_mode, tx_mode;
    logic [7:0]  rx_stratum, rx_poll, tx_stratum;
    logic [63:0] rx_xmt_ts, tx_ts, t0, t1;
    logic [7:0]  ad [4] = '{A_PEER_ADDR, A_PEER_PORT, A_LOC_ADDR, A_LOC_PORT};
    int          st [6] = '{1, 2, 15, 16, 255, 0};
    int          errors = 0, checks_done = 0, ticks = 0, n0, seed = 32'hde4fb65c;

    time_sync_state #(.MAX_AGE(50), .HOLD_SET(16'h0002)) i_dut (.*);
    peer_model i_peer (.*);

    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (sec_tick === 1'b1) ticks <= ticks + 1;

    task automatic chk(input logic [63:0] g, e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // The master waits for the slave; only the watchdog ends a hung bus.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic depart(output logic [63:0] t);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        @(posedge clk);
        chk(tx_ts_valid, 1'b1);
        t = tx_ts;
    endtask : depart

    // A zero stratum ranks above every other value.
    function automatic int rank(int v);
        return (v == 0) ? 256 : v;
    endfunction : rank

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(A_STRATUM, 32'h00000f00);
        rd(A_PREC, 32'h000000f6);
        rd(A_STATUS, 32'h00000003);
        rd(A_REF_HI, 32'h0);
        rd(8'h80, 32'h0);
        rd(A_INCR, 32'h0000006b);
        foreach (ad[i]) begin
            h = $random(seed);
            bus(1'b1, ad[i], h);
            rd(ad[i], (i % 2) ? h & 32'h0000ffff : h);
        end
        $display("test reset and address done");
        bus(1'b1, A_INCR, 32'h40000000);
        n0 = ticks;
        repeat (44) @(posedge clk);
        chk(ticks - n0, 10);
        depart(t0);
        depart(t1);
        chk(t1 - t0, 64'h80000000);
        $display("test tick and departure done");
        // Freeze the clock and keep bit 32 on the step, so no tick eats the hold.
        bus(1'b1, A_INCR, 32'h0);
        bus(1'b0, A_CLK_HI, 32'h0);
        h = 32'h00001000 | (q & 32'h1);
        bus(1'b1, A_CLK_LO, 32'h0);
        bus(1'b1, A_CLK_HI, h);
        rd(A_HOLD, 32'h00000002);
        rd(A_REF_HI, h);
        bus(1'b1, A_CLK_HI, 32'h00002000);
        rd(A_REF_HI, h);
        bus(1'b1, A_INCR, 32'h01000000);
        repeat (600) @(posedge clk);
        rd(A_HOLD, 32'h0);
        bus(1'b1, A_CLK_HI, 32'h00003000);
        rd(A_REF_HI, 32'h00003000);
        $display("test hold done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, A_CTRL, (i << 3) | ((i % 3) << 1) | 1);
            repeat (2) @(posedge clk);
            chk(tx_mode, i);
            chk(leap_out, i % 3);
        end
        h = $random(seed);
        bus(1'b1, A_REF_CODE, 32'h41424300);
        bus(1'b1, A_REF_HOST, h);
        foreach (st[i]) begin
            bus(1'b1, A_STRATUM, {24'h00000f, st[i][7:0]});
            repeat (2) @(posedge clk);
            chk(tx_stratum, (rank(st[i]) > 15) ? 15 : st[i]);
            chk(tx_refid, (st[i] < 2) ? 32'h41424300 : h);
        end
        $display("test mode leap stratum done");
        bus(1'b1, A_CTRL, 32'h0);
        for (int m = 6; m < 8; m++) begin
            t0 = {$random(seed), $random(seed)};
            i_peer.send(LEAP_DEL, m, 8'h05, 8'h06, t0, m - 6);
            rd(A_ORG_HI, t0[63:32]);
            rd(A_ORG_LO, t0[31:0]);
            bus(1'b0, A_STATUS, 32'h0);
            chk(q[10:8], m);
            chk(q[3], 1'b1);
            chk(leap_out, LEAP_DEL);
            bus(1'b0, A_PREC, 32'h0);
            chk(q[15:8], 8'h06);
        end
        i_peer.drop();
        rd(A_ORG_HI, 32'h0);
        rd(A_REC_HI, 32'h0);
        rd(A_REC_LO, 32'h0);
        $display("test peer done");
        bus(1'b1, A_UPDATE, 32'h00000002);
        repeat (2) @(posedge clk);
        chk({clock_synced, leap_out}, 3'b011);
        bus(1'b1, A_INCR, 32'h40000000);
        bus(1'b1, A_UPDATE, 32'h00000001);
        chk(clock_synced, 1'b1);
        repeat (212) @(posedge clk);
        chk({clock_synced, leap_out}, 3'b011);
        $display("test alarm done");
        test_done();
    end
endmodule : time_sync_state_tb

bind time_sync_state time_sync_state_asserts i_chk (.*);
`default_nettype wire
